// File: common/stop_consts.svh
// constants for the stop-mode and port configuration block
// included by the counter, control and bench files; definitions only
`ifndef STOP_CONSTS_SVH
`define STOP_CONSTS_SVH
`define ADDR_PORT_CFG      8'h00
`define ADDR_WAKE_ONE      8'h0b
`define ADDR_WAKE_TWO      8'h0d
`define PORT_CFG_RST       8'hfe
`define WAKE_ONE_RST       8'h20
`define WAKE_TWO_RST       8'h00
`define RESTART_VECTOR     16'h000c
`define NOP_OPCODE         8'hff
`define W1_FLAG            7
`define W1_LEVEL           6
`define W1_DELAY           5
`define W1_SRC_HI          4
`define W1_SRC_LO          2
`define W1_BYPASS          1
`define W1_DIV16           0
`define PC_COMP            0
`define PC_P0_PUSHPULL     2
`define PC_P0_STD          3
`define PC_P2_STD          5
`define PC_P3_STD          6
`define PC_OSC_STD         7
`define POR_DELAY_NS       1000
`define POR_DELAY_CYC      ((`POR_DELAY_NS + 19) / 20)
`endif

// File: common/stop_pkg.sv
// types for the stop-mode and port configuration block
// used by stop_mode_ctrl through stop_pkg::name
package stop_pkg;
  typedef enum logic [1:0] {
    st_run,
    st_stopped,
    st_delay
  } power_state_t;
endpackage : stop_pkg

// File: src/wake_source_select.sv
// picks the wake source from the two source fields and tests its level
// assumes pin levels are synchronous to clk_sys
`timescale 1ns/10ps
module wake_source_select (
  input  wire logic [2:0] src_one,
  input  wire logic [1:0] src_two,
  input  wire logic       level_high,
  input  wire logic [7:0] port2_pins,
  input  wire logic [3:0] port3_low_pins,
  output logic            wake_match
);
  logic raw;

  // the level bit applies to either register's source
  always_comb begin
    raw = 1'b0;
    case (src_one)
      3'h1: raw = port3_low_pins[0];
      3'h2: raw = port3_low_pins[1];
      3'h3: raw = port3_low_pins[2];
      3'h4: raw = port3_low_pins[3];
      3'h5: raw = port2_pins[7];
      3'h6: raw = ~|port2_pins[3:0];
      3'h7: raw = ~|port2_pins;
      default: raw = 1'b0;
    endcase
    case (src_two)
      2'h1: raw = raw | (&port2_pins[3:0]);
      2'h2: raw = raw | (&port2_pins);
      default: raw = raw;
    endcase
    // source zero means reset only: never a match
    wake_match = ((src_one != 3'h0) || (src_two == 2'h1) || (src_two == 2'h2))
                 && (raw == level_high);
  end
endmodule : wake_source_select

// File: src/delay_counter.sv
// one-shot delay counter used for the power-on delay after wake
// assumes start is a one-cycle pulse
`timescale 1ns/10ps
`include "stop_consts.svh"
module delay_counter #(
  parameter logic [15:0] COUNT = 16'(`POR_DELAY_CYC)
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      done
);
  logic [15:0] cnt_q;

  // counts down; done pulses on reaching one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
    end else if (start) begin
      cnt_q <= COUNT;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  assign done = (cnt_q == 16'h0001);
endmodule : delay_counter

// File: src/stop_mode_ctrl.sv
// stop-mode control, clock division select and port configuration
// assumes register writes and the stop strobe come from the cpu core
// Operation
// - stop halts clock, oscillator, comparators
// - stop ends on wake; restart at 000ch
// - watchdog wake always applies the delay
// - permanent rc watchdog cannot be stopped
// - d0 routes comparator outputs to pins
// - d2 selects port 0 open drain
// - d3 selects port 0 low emission
// - d5, d6 select port 2, 3 emission
// - d7 selects oscillator drive
// - bit 7 warm flag, read only
// - bit 6 selects wake level
// - bit 5 enables wake delay
// - bits 4-2 select wake source
// - d1 bypasses crystal halving
// - d0 adds divide-by-16 prescaler
// - second register bits 1-0 select source
// - second register source encoding
`timescale 1ns/10ps
`include "stop_consts.svh"
module stop_mode_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        por_event,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  input  wire logic        stop_exec,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_permanent,
  input  wire logic        watchdog_rc_source,
  input  wire logic [7:0]  port2_pins,
  input  wire logic [3:0]  port3_low_pins,
  output logic [7:0]       reg_rdata,
  output logic             core_clock_run,
  output logic             osc_run,
  output logic             comparator_power,
  output logic             cpu_hold,
  output logic             restart_pulse,
  output logic [15:0]      restart_vector,
  output logic             watchdog_run,
  output logic             comp_to_pins,
  output logic             port0_push_pull,
  output logic             port0_std_drive,
  output logic             port2_std_drive,
  output logic             port3_std_drive,
  output logic             osc_std_drive,
  output logic             osc_halving_bypass,
  output logic             div16_enable,
  output logic             sysclk_tick
);
  stop_pkg::power_state_t state_q;
  logic [7:0] port_cfg_q;
  logic [6:0] wake_one_q;
  logic [1:0] wake_two_q;
  logic       warm_wake_flag_q;
  logic       wake_match;
  logic       delay_start;
  logic       delay_done;
  logic       wake_now;
  logic       need_delay;
  logic [4:0] div_q;

  // helper: is this a write to the given address
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction : wr_hit

  wake_source_select u_src (
    .src_one        (wake_one_q[`W1_SRC_HI:`W1_SRC_LO]),
    .src_two        (wake_two_q),
    .level_high     (wake_one_q[`W1_LEVEL]),
    .port2_pins     (port2_pins),
    .port3_low_pins (port3_low_pins),
    .wake_match     (wake_match)
  );

  delay_counter u_delay (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (delay_start),
    .done    (delay_done)
  );

  // a watchdog time-out wakes like a source but forces the delay
  assign wake_now   = (state_q == stop_pkg::st_stopped) && (wake_match || watchdog_timeout);
  assign need_delay = watchdog_timeout || wake_one_q[`W1_DELAY];
  assign delay_start = wake_now && need_delay;

  // port configuration; write only, reserved bits kept at one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_cfg_q <= `PORT_CFG_RST;
    end else if (wr_hit(`ADDR_PORT_CFG)) begin
      port_cfg_q <= reg_wdata | 8'h12;
    end
  end

  // wake control one: writable bits 6..0; any wake, source or watchdog, clears the divide-by-16
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_one_q <= 7'(`WAKE_ONE_RST);
    end else if (wr_hit(`ADDR_WAKE_ONE)) begin
      wake_one_q <= reg_wdata[6:0];
    end else if (wake_now) begin
      wake_one_q[`W1_DIV16] <= 1'b0;
    end
  end

  // wake control two: only the source field is kept, reserved bits drop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_two_q <= 2'(`WAKE_TWO_RST);
    end else if (wr_hit(`ADDR_WAKE_TWO)) begin
      wake_two_q <= reg_wdata[1:0];
    end
  end

  // warm flag: set by a source wake, not by a watchdog wake; cleared only by a power-on cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst && por_event) begin
      warm_wake_flag_q <= 1'b0;
    end else if (wake_now && !watchdog_timeout) begin
      warm_wake_flag_q <= 1'b1;
    end
  end

  // power state: stop, then wait for a match or time-out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= stop_pkg::st_run;
    end else begin
      case (state_q)
        stop_pkg::st_run: begin
          if (stop_exec) begin
            state_q <= stop_pkg::st_stopped;
          end
        end
        stop_pkg::st_stopped: begin
          if (wake_now) begin
            state_q <= need_delay ? stop_pkg::st_delay : stop_pkg::st_run;
          end
        end
        stop_pkg::st_delay: begin
          if (delay_done) begin
            state_q <= stop_pkg::st_run;
          end
        end
        default: state_q <= stop_pkg::st_run;
      endcase
    end
  end

  // restart pulse toward the core when returning to run from stop or delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      restart_pulse <= 1'b1;
    end else begin
      restart_pulse <= (wake_now && !need_delay) ||
                       ((state_q == stop_pkg::st_delay) && delay_done);
    end
  end

  // clock and power enables, registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      core_clock_run   <= 1'b1;
      osc_run          <= 1'b1;
      comparator_power <= 1'b1;
      cpu_hold         <= 1'b0;
      watchdog_run     <= 1'b0;
    end else begin
      core_clock_run   <= (state_q == stop_pkg::st_run) && !stop_exec;
      osc_run          <= !((state_q == stop_pkg::st_run) ? stop_exec :
                            ((state_q == stop_pkg::st_stopped) && !wake_now));
      comparator_power <= (state_q == stop_pkg::st_run) && !stop_exec;
      cpu_hold         <= (state_q != stop_pkg::st_run) || stop_exec;
      watchdog_run     <= (watchdog_permanent && watchdog_rc_source) ||
                          (state_q == stop_pkg::st_run);
    end
  end

  // configuration outputs, registered copies of the fields
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      comp_to_pins       <= 1'b0;
      port0_push_pull    <= 1'b1;
      port0_std_drive    <= 1'b1;
      port2_std_drive    <= 1'b1;
      port3_std_drive    <= 1'b1;
      osc_std_drive      <= 1'b1;
      osc_halving_bypass <= 1'b0;
      div16_enable       <= 1'b0;
      restart_vector     <= `RESTART_VECTOR;
    end else begin
      comp_to_pins       <= port_cfg_q[`PC_COMP];
      port0_push_pull    <= port_cfg_q[`PC_P0_PUSHPULL];
      port0_std_drive    <= port_cfg_q[`PC_P0_STD];
      port2_std_drive    <= port_cfg_q[`PC_P2_STD];
      port3_std_drive    <= port_cfg_q[`PC_P3_STD];
      osc_std_drive      <= port_cfg_q[`PC_OSC_STD];
      osc_halving_bypass <= wake_one_q[`W1_BYPASS];
      div16_enable       <= wake_one_q[`W1_DIV16];
      restart_vector     <= `RESTART_VECTOR;
    end
  end

  // system clock tick: every clock, every 2nd, or 16x slower; halted in stop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_q       <= 5'h00;
      sysclk_tick <= 1'b0;
    end else if (state_q != stop_pkg::st_run) begin
      div_q       <= 5'h00;
      sysclk_tick <= 1'b0;
    end else begin
      div_q       <= div_q + 5'h01;
      case ({wake_one_q[`W1_DIV16], wake_one_q[`W1_BYPASS]})
        2'b01:   sysclk_tick <= 1'b1;
        2'b00:   sysclk_tick <= div_q[0];
        2'b11:   sysclk_tick <= (div_q[3:0] == 4'hf);
        default: sysclk_tick <= (div_q == 5'h1f);
      endcase
    end
  end

  // read port: only the warm flag is readable, other bits read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && (reg_addr == `ADDR_WAKE_ONE)) begin
      reg_rdata <= {warm_wake_flag_q, 7'h00};
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : stop_mode_ctrl

// File: test/stop_mode_ctrl_properties.sv
// port assertions for the stop-mode control block
// bound onto stop_mode_ctrl from the bench top; one clock domain
`timescale 1ns/10ps
module stop_mode_ctrl_properties (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic        stop_exec,
  input wire logic        watchdog_timeout,
  input wire logic        watchdog_permanent,
  input wire logic        watchdog_rc_source,
  input wire logic [7:0]  reg_rdata,
  input wire logic        core_clock_run,
  input wire logic        osc_run,
  input wire logic        comparator_power,
  input wire logic        cpu_hold,
  input wire logic        restart_pulse,
  input wire logic [15:0] restart_vector,
  input wire logic        watchdog_run,
  input wire logic        comp_to_pins,
  input wire logic        port0_push_pull,
  input wire logic        osc_halving_bypass,
  input wire logic        div16_enable
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // a stop taken while running drops both clocks and the comparators
  AST_STOP_HALT: assert property (stop_exec && !cpu_hold |=>
    !core_clock_run && !osc_run && !comparator_power) else $error("stop did not halt");
  // every restart points at the fixed restart address
  AST_VECTOR: assert property (restart_pulse |-> restart_vector == 16'h000c)
    else $error("restart vector wrong");
  // clocks are back the cycle after the restart pulse
  AST_RESUME: assert property (restart_pulse |=> core_clock_run && osc_run)
    else $error("clocks not resumed");
  // port settings follow the written byte two cycles later
  AST_PORT_CFG: assert property (reg_wr && reg_addr == 8'h00 |-> ##2
    comp_to_pins == $past(reg_wdata[0], 2) && port0_push_pull == $past(reg_wdata[2], 2))
    else $error("port setting wrong");
  AST_CLK_SEL: assert property (reg_wr && reg_addr == 8'h0b |-> ##2
    {osc_halving_bypass, div16_enable} == $past(reg_wdata[1:0], 2))
    else $error("clock select wrong");
  // only the warm flag is ever readable
  AST_FLAG_RO: assert property (reg_rd |=> reg_rdata[6:0] == 7'h00)
    else $error("write-only bits read back");
  AST_WDOG_KEEP: assert property (watchdog_permanent && watchdog_rc_source |=> watchdog_run)
    else $error("watchdog stopped");
  // a watchdog wake never skips the power-on delay
  AST_WDOG_DELAY: assert property (watchdog_timeout && !core_clock_run |=>
    (!restart_pulse)[*8] ##[1:100] restart_pulse) else $error("watchdog wake delay");
endmodule : stop_mode_ctrl_properties

// File: test/stop_mode_ctrl_tb_top.sv
// self-checking bench for the stop-mode control block
// one process drives all inputs but the clock 1 ns after the rising edge
`timescale 1ns/10ps
`include "stop_consts.svh"
module stop_mode_ctrl_tb_top;
  logic        clk_sys, sys_rst, por_event, reg_wr, reg_rd, stop_exec, watchdog_timeout;
  logic        watchdog_permanent, watchdog_rc_source, restart_pulse, cpu_hold, osc_run;
  logic        core_clock_run, comparator_power, watchdog_run, comp_to_pins, port0_push_pull;
  logic        port0_std_drive, port2_std_drive, port3_std_drive, osc_std_drive;
  logic        osc_halving_bypass, div16_enable, sysclk_tick;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, port2_pins;
  logic [3:0]  port3_low_pins;
  logic [15:0] restart_vector;
  logic [5:0]  pc_seen;
  int          n_mismatch = 0, compares = 0, pc_m, n, i, k;

  stop_mode_ctrl u_dut (.*);
  assign pc_seen = {osc_std_drive, port3_std_drive, port2_std_drive,
                    port0_std_drive, port0_push_pull, comp_to_pins};
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1); // a clock passes so a following write never re-raises the strobe at once
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    chk(reg_rdata, e);
  endtask : rd_chk
  // model of port settings: which written bits show on which outputs
  function automatic logic [5:0] pc_out(int v);
    return {v[7], v[6], v[5], v[3], v[2], v[0]};
  endfunction : pc_out
  // model of the wake source level for codes 1-7 (first field), 8-9 (second)
  function automatic logic src_lvl(int c, logic [7:0] p2, logic [3:0] p3);
    case (c)
      1, 2, 3, 4: return p3[c-1];
      5: return p2[7];
      6: return ~|p2[3:0];
      7: return ~|p2;
      8: return &p2[3:0];
      default: return &p2;
    endcase
  endfunction : src_lvl
  // random pins until the source shows the wanted level; bounded search
  task automatic pins(input int c, input logic want);
    logic [7:0] p2;
    logic [3:0] p3;
    for (int t = 0; t < 4000; t++) begin
      p2 = 8'($urandom);
      p3 = 4'($urandom);
      if (src_lvl(c, p2, p3) == want) begin
        port2_pins = p2;
        port3_low_pins = p3;
        return;
      end
    end
    chk(0, 1);
    wrap_up();
  endtask : pins
  task automatic wait_restart(input int lim);
    n = 0;
    while (restart_pulse !== 1'b1) begin
      if (n == lim) begin
        chk(0, 1);
        wrap_up();
      end
      cyc(1);
      n++;
    end
  endtask : wait_restart

  initial begin
    {reg_wr, reg_rd, stop_exec, watchdog_timeout, watchdog_permanent} = 0;
    {watchdog_rc_source, reg_addr, reg_wdata, port2_pins, port3_low_pins} = 0;
    sys_rst = 1;
    por_event = 1;
    k = $urandom(11);
    cyc(4);
    sys_rst = 0;
    por_event = 0;
    pc_m = 'hfe;
    chk(pc_seen, pc_out(pc_m));
    chk({osc_halving_bypass, div16_enable}, 0);
    rd_chk(8'h0b, 8'h00);
    // random port settings; the stray write to an unmapped place must be ignored
    for (i = 0; i < 8; i++) begin
      pc_m = $urandom;
      wr(8'h00, pc_m[7:0]);
      wr(8'h05, ~pc_m[7:0]);
      cyc(1);
      chk(pc_seen, pc_out(pc_m));
    end
    // tick count over 256 cycles per divider setting, one tick of phase slack
    for (i = 0; i < 4; i++) begin
      wr(8'h0b, 8'(i));
      cyc(2);
      n = 0;
      repeat (256) begin
        cyc(1);
        n += sysclk_tick;
      end
      k = 256 / ((i[0] ? 16 : 1) * (i[1] ? 1 : 2));
      chk(n >= k - 1 && n <= k + 1, 1);
    end
    // each wake source at both levels; odd sources also use the delay
    for (k = 0; k < 18; k++) begin
      i = k / 2 + 1;
      pins(i, !k[0]);
      wr(8'h0b, {1'b0, k[0], i[0], 3'(i < 8 ? i : 0), 2'b00});
      wr(8'h0d, 8'(i < 8 ? 0 : i - 7));
      stop_exec = 1;
      cyc(1);
      stop_exec = 0;
      cyc(3);
      chk({cpu_hold, osc_run, comparator_power, restart_pulse}, 4'b1000);
      pins(i, k[0]);
      wait_restart(i[0] ? 80 : 4);
      chk(n >= (i[0] ? `POR_DELAY_CYC : 0), 1);
      chk(restart_vector, `RESTART_VECTOR);
      cyc(2);
      rd_chk(8'h0b, 8'h80);
    end
    // watchdog wake with the delay off; settings must survive it
    wr(8'h0b, 8'h00);
    wr(8'h0d, 8'h00);
    watchdog_permanent = 1;
    watchdog_rc_source = 1;
    stop_exec = 1;
    cyc(1);
    stop_exec = 0;
    cyc(2);
    watchdog_timeout = 1;
    cyc(1);
    watchdog_timeout = 0;
    chk(watchdog_run, 1);
    wait_restart(80);
    chk(n >= `POR_DELAY_CYC - 2, 1);
    chk(pc_seen, pc_out(pc_m));
    wrap_up();
  end
endmodule : stop_mode_ctrl_tb_top

bind stop_mode_ctrl stop_mode_ctrl_properties u_props (.*);
